/* design/ebc_pkg.sv */
/*
  Shared constants for the external bus configuration block: mode and
  format encodings, pin lane positions, reset values and sync layout.
  Assumes one system clock domain; ports 0..3, the bus clock and the strap pin are sampled by the top level.
*/
package ebc_pkg;
    localparam int SPACES = 4;
    localparam int WAIT_W = 5;
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int NPORTS = 6;
    localparam logic [1:0] MODE_SINGLE = 2'h0;
    localparam logic [1:0] MODE_EXPAND = 2'h1;
    localparam logic [1:0] MODE_MICRO = 2'h3;
    localparam logic [1:0] FMT_SEP = 2'h0;
    localparam logic [1:0] FMT_MUX_CS1 = 2'h1;
    localparam logic [1:0] FMT_MUX_CS2 = 2'h2;
    localparam logic [1:0] FMT_MUX_ALL = 2'h3;
    localparam logic [1:0] LATCH_NONE = 2'h0;
    localparam logic [1:0] LATCH_ON_CLK = 2'h1;
    localparam logic [1:0] LATCH_ON_HACK = 2'h2;
    localparam logic [1:0] LATCH_ON_PIN = 2'h3;
    // Port lanes
    localparam int PORT_DLO = 0;
    localparam int PORT_DHI = 1;
    localparam int PORT_ALO = 2;
    localparam int PORT_AHI = 3;
    localparam int PORT_ATOP = 4;
    localparam int PORT_CTL = 5;
    // Control port bit positions
    localparam int CTL_READ = 0;
    localparam int CTL_WLO = 1;
    localparam int CTL_WHI = 2;
    localparam int CTL_CLK = 3;
    localparam int CTL_HACK = 4;
    localparam int CTL_HOLD = 5;
    localparam int CTL_LATCH = 6;
    localparam int CTL_READY = 7;
    localparam int STRAP_SPACE = 3;
    localparam logic [3:0] WIDTH_RESET = 4'h0;
    localparam logic [3:0] CS_IDLE = 4'hf;
    localparam logic [WAIT_W-1:0] WAIT_RESET = 5'h00;
    // Strap is taken once the synchroniser has filled after release
    localparam logic [1:0] STRAP_DELAY = 2'h2;
    localparam logic [1:0] STRAP_DONE = 2'h3;
    // Synchroniser layout: ports 0..3 data, then bus clock, then strap
    localparam int SYNC_W = 34;
    localparam int SYNC_CLK = 32;
    localparam int SYNC_STRAP = 33;
    typedef enum logic [1:0] {EBC_IDLE, EBC_ADDR, EBC_STROBE, EBC_DONE} ebc_state_t;
endpackage

/* design/ebc_sync_if.sv */
/*
  Carrier between the top level and its pin synchroniser.
  Assumes the raw side is driven from pins outside the clock domain.
*/
`timescale 1ns/1ps
interface ebc_sync_if #(parameter int W = 1);
    logic [W-1:0] raw;
    logic [W-1:0] synced;
    modport sync_side (input raw, output synced);
    modport user_side (output raw, input synced);
endinterface

/* design/ebc_sync.sv */
/*
  Two-stage synchroniser for pin inputs and the sampled bus clock.
  Assumes raw inputs are asynchronous to i_clk.
*/
`timescale 1ns/1ps
module ebc_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // Pins in, sampled out
    ebc_sync_if.sync_side sif
);
    logic [W-1:0] meta;
    logic [W-1:0] stable;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_stable;

    // First stage feeds only the second stage
    always_comb begin
        next_meta = sif.raw;
        next_stable = meta;
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            meta <= '0;
            stable <= '0;
        end else begin
            meta <= next_meta;
            stable <= next_stable;
        end
    end

    assign sif.synced = stable;
endmodule

/* design/ebc_top.sv */
/*
  External bus configuration and pin assignment: width and wait settings
  per space, access sequencing on bus clock edges, and the pin multiplexer.
  Assumes configuration inputs come from software-written registers on
  i_clk, and that pins and the bus clock arrive asynchronously.
*/
`timescale 1ns/1ps
module ebc_top (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // Mode and configuration bits
    input wire logic [1:0] i_proc_mode,
    input wire logic i_bus_format_high,
    input wire logic i_bus_format_low,
    input wire logic i_space_mode_high,
    input wire logic i_space_mode_low,
    input wire logic i_latch_pin_sel_high,
    input wire logic i_latch_pin_sel_low,
    input wire logic i_strobe_style_bit,
    // Width and wait settings
    input wire logic i_width_wr,
    input wire logic [ebc_pkg::SPACES-1:0] i_width_data,
    output logic [ebc_pkg::SPACES-1:0] o_width_select_reg,
    input wire logic i_wait_wr,
    input wire logic [1:0] i_wait_idx,
    input wire logic [ebc_pkg::WAIT_W-1:0] i_wait_data,
    output logic [ebc_pkg::WAIT_W-1:0] o_wait_states,
    // Access request and answer
    input wire logic i_acc_req,
    input wire logic [1:0] i_acc_space,
    input wire logic [ebc_pkg::ADDR_W-1:0] i_acc_addr,
    input wire logic i_acc_write,
    input wire logic [1:0] i_acc_byte_en,
    input wire logic [ebc_pkg::DATA_W-1:0] i_acc_wdata,
    output logic o_acc_ready,
    output logic o_acc_done,
    output logic [ebc_pkg::DATA_W-1:0] o_acc_rdata,
    // Pins
    input wire logic i_reset_width_pin,
    input wire logic i_bus_clk,
    input wire logic [ebc_pkg::NPORTS-1:0][7:0] i_pin_in,
    input wire logic [ebc_pkg::NPORTS-1:0][7:0] i_io_out,
    input wire logic [ebc_pkg::NPORTS-1:0][7:0] i_io_oe,
    output logic [ebc_pkg::NPORTS-1:0][7:0] o_pin_out,
    output logic [ebc_pkg::NPORTS-1:0][7:0] o_pin_oe,
    output logic [ebc_pkg::NPORTS-1:0][7:0] o_pin_is_bus
);
    import ebc_pkg::*;

    function automatic logic is_mux(input logic [1:0] fmt, input logic [1:0] sp);
        is_mux = (fmt == FMT_MUX_ALL) || (fmt == FMT_MUX_CS1 && sp == 2'h1) ||
                 (fmt == FMT_MUX_CS2 && sp == 2'h2);
    endfunction

    // Number of chip-select pins for a space-mode value
    function automatic logic [2:0] cs_count(input logic [1:0] sm);
        unique case (sm)
            2'h0: cs_count = 3'h0;
            2'h1: cs_count = 3'h3;
            2'h2: cs_count = 3'h2;
            2'h3: cs_count = 3'h4;
        endcase
    endfunction

    ebc_sync_if #(.W(SYNC_W)) sif ();

    ebc_sync #(.W(SYNC_W)) u_sync (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .sif(sif)
    );

    assign sif.raw = {i_reset_width_pin, i_bus_clk, i_pin_in[3], i_pin_in[2], i_pin_in[1], i_pin_in[0]};

    logic [1:0] fmt_raw;
    logic [1:0] fmt_eff;
    logic [1:0] space_mode;
    logic [1:0] latch_sel;
    logic bus_mode;
    logic all_mux;
    logic any_wide;
    logic bclk_now;
    logic bclk_prev;
    logic bclk_rise;

    // Decoded configuration
    assign fmt_raw = {i_bus_format_high, i_bus_format_low};
    assign space_mode = {i_space_mode_high, i_space_mode_low};
    assign latch_sel = {i_latch_pin_sel_high, i_latch_pin_sel_low};
    // bus roles only in expansion or microprocessor mode; 10 counts as single
    assign bus_mode = (i_proc_mode == MODE_EXPAND) || (i_proc_mode == MODE_MICRO);
    // all-mux format refused in microprocessor mode, separate used instead
    assign fmt_eff = (!bus_mode || (i_proc_mode == MODE_MICRO && fmt_raw == FMT_MUX_ALL)) ? FMT_SEP : fmt_raw;
    assign all_mux = (fmt_eff == FMT_MUX_ALL);
    assign bclk_now = sif.synced[SYNC_CLK];
    assign bclk_rise = bclk_now && !bclk_prev;

    // Width bits with one-time strap capture for space 3
    logic [SPACES-1:0] width_reg;
    logic [SPACES-1:0] next_width_reg;
    logic [1:0] strap_cnt;
    logic [1:0] next_strap_cnt;
    logic next_bclk_prev;

    // strap taken after the synchroniser has filled; software write wins
    // the pin is read once, so later changes on it are not followed
    always_comb begin
        next_width_reg = width_reg;
        next_strap_cnt = strap_cnt;
        next_bclk_prev = bclk_now;
        if (strap_cnt != STRAP_DONE) begin
            next_strap_cnt = strap_cnt + 2'h1;
        end
        if (strap_cnt == STRAP_DELAY) begin
            next_width_reg[STRAP_SPACE] = !sif.synced[SYNC_STRAP];
        end
        // per-space width bits, one means 16-bit
        if (i_width_wr) begin
            next_width_reg = i_width_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            width_reg <= WIDTH_RESET;
            strap_cnt <= 2'h0;
            bclk_prev <= 1'b0;
        end else begin
            width_reg <= next_width_reg;
            strap_cnt <= next_strap_cnt;
            bclk_prev <= next_bclk_prev;
        end
    end

    assign any_wide = |width_reg;
    assign o_width_select_reg = width_reg;

    // Wait-state settings, one per space
    logic [SPACES-1:0][WAIT_W-1:0] wait_reg;
    logic [SPACES-1:0][WAIT_W-1:0] next_wait_reg;

    // each space keeps its own wait count
    always_comb begin
        next_wait_reg = wait_reg;
        if (i_wait_wr) begin
            next_wait_reg[i_wait_idx] = i_wait_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            wait_reg <= {SPACES{WAIT_RESET}};
        end else begin
            wait_reg <= next_wait_reg;
        end
    end

    // Access sequencer, stepped by sampled bus clock rising edges
    ebc_state_t state;
    ebc_state_t next_state;
    logic [1:0] acc_space;
    logic [1:0] next_acc_space;
    logic [ADDR_W-1:0] acc_addr;
    logic [ADDR_W-1:0] next_acc_addr;
    logic acc_write;
    logic next_acc_write;
    logic [1:0] acc_be;
    logic [1:0] next_acc_be;
    logic [DATA_W-1:0] acc_wdata;
    logic [DATA_W-1:0] next_acc_wdata;
    logic [WAIT_W-1:0] wait_cnt;
    logic [WAIT_W-1:0] next_wait_cnt;
    logic [SPACES-1:0] cs_n;
    logic [SPACES-1:0] next_cs_n;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] next_rdata;
    logic acc_wide;
    logic cur_mux;
    logic [7:0] rd_lo;
    logic [7:0] rd_hi;

    assign acc_wide = width_reg[acc_space];
    assign cur_mux = is_mux(fmt_eff, acc_space);
    // internal data is 16 bits; narrow reads return zero upper byte
    assign rd_lo = cur_mux ? sif.synced[23:16] : sif.synced[7:0];
    assign rd_hi = !acc_wide ? 8'h00 : (cur_mux ? sif.synced[31:24] : sif.synced[15:8]);

    // Next state and latched access; address and selects hold between accesses
    always_comb begin
        next_state = state;
        next_acc_space = acc_space;
        next_acc_addr = acc_addr;
        next_acc_write = acc_write;
        next_acc_be = acc_be;
        next_acc_wdata = acc_wdata;
        next_wait_cnt = wait_cnt;
        next_cs_n = cs_n;
        next_rdata = rdata;
        unique case (state)
            EBC_IDLE: begin
                if (i_acc_req && bus_mode) begin
                    next_state = EBC_ADDR;
                    next_acc_space = i_acc_space;
                    next_acc_addr = i_acc_addr;
                    next_acc_write = i_acc_write;
                    next_acc_be = i_acc_byte_en;
                    next_acc_wdata = i_acc_wdata;
                    // only the addressed area's select goes low
                    next_cs_n = ~(4'h1 << i_acc_space);
                end
            end
            EBC_ADDR: begin
                if (bclk_rise) begin
                    next_state = EBC_STROBE;
                    next_wait_cnt = wait_reg[acc_space];
                end
            end
            EBC_STROBE: begin
                if (bclk_rise) begin
                    if (wait_cnt == '0) begin
                        next_state = EBC_DONE;
                        if (!acc_write) begin
                            next_rdata = {rd_hi, rd_lo};
                        end
                    end else begin
                        next_wait_cnt = wait_cnt - 1'b1;
                    end
                end
            end
            EBC_DONE: begin
                next_state = EBC_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state <= EBC_IDLE;
            acc_space <= 2'h0;
            acc_addr <= '0;
            acc_write <= 1'b0;
            acc_be <= 2'h0;
            acc_wdata <= '0;
            wait_cnt <= '0;
            cs_n <= CS_IDLE;
            rdata <= '0;
        end else begin
            state <= next_state;
            acc_space <= next_acc_space;
            acc_addr <= next_acc_addr;
            acc_write <= next_acc_write;
            acc_be <= next_acc_be;
            acc_wdata <= next_acc_wdata;
            wait_cnt <= next_wait_cnt;
            cs_n <= next_cs_n;
            rdata <= next_rdata;
        end
    end

    assign o_acc_ready = (state == EBC_IDLE) && bus_mode;
    assign o_acc_done = (state == EBC_DONE);
    assign o_acc_rdata = rdata;
    assign o_wait_states = wait_reg[acc_space];

    // Pin multiplexer
    logic strobe;
    logic drive_w;
    logic mux_data;
    logic mux_hi;
    logic ale;
    logic split;
    logic [2:0] n_cs;

    assign strobe = (state == EBC_STROBE);
    assign drive_w = strobe && acc_write;
    assign mux_data = cur_mux && strobe;
    // wide multiplexed spaces also share the upper address byte
    assign mux_hi = mux_data && acc_wide;
    assign ale = (state == EBC_ADDR);
    // Narrow accesses fall back to the single write strobe set automatically
    assign split = i_strobe_style_bit && acc_wide;
    assign n_cs = cs_count(space_mode);

    // roles follow mode, format, widths and the access in progress
    always_comb begin
        o_pin_out = i_io_out;
        o_pin_oe = i_io_oe;
        o_pin_is_bus = '0;
        if (bus_mode) begin
            // all-multiplexed leaves ports zero, one and A16-A19 as I/O
            if (!all_mux) begin
                // separate data on port zero, port one only if any space wide
                o_pin_is_bus[PORT_DLO] = 8'hff;
                o_pin_out[PORT_DLO] = acc_wdata[7:0];
                o_pin_oe[PORT_DLO] = {8{drive_w && !cur_mux}};
                if (any_wide) begin
                    o_pin_is_bus[PORT_DHI] = 8'hff;
                    o_pin_out[PORT_DHI] = acc_wdata[15:8];
                    // upper byte left floating on narrow-space accesses
                    o_pin_oe[PORT_DHI] = {8{drive_w && !cur_mux && acc_wide}};
                end
                o_pin_is_bus[PORT_ATOP][3:0] = 4'hf;
                o_pin_out[PORT_ATOP][3:0] = acc_addr[19:16];
                o_pin_oe[PORT_ATOP][3:0] = 4'hf;
            end
            // only multiplexed areas turn port two into data; port three only when the area is also wide
            o_pin_is_bus[PORT_ALO] = 8'hff;
            o_pin_out[PORT_ALO] = mux_data ? acc_wdata[7:0] : acc_addr[7:0];
            o_pin_oe[PORT_ALO] = {8{!mux_data || drive_w}};
            o_pin_is_bus[PORT_AHI] = 8'hff;
            o_pin_out[PORT_AHI] = mux_hi ? acc_wdata[15:8] : acc_addr[15:8];
            o_pin_oe[PORT_AHI] = {8{!mux_hi || drive_w}};
            // top pins carry chip-selects or high address bits
            for (int k = 0; k < 4; k++) begin
                o_pin_is_bus[PORT_ATOP][4+k] = 1'b1;
                o_pin_oe[PORT_ATOP][4+k] = 1'b1;
                if (3'(k) < n_cs) begin
                    o_pin_out[PORT_ATOP][4+k] = cs_n[k];
                end else begin
                    o_pin_out[PORT_ATOP][4+k] = acc_addr[20+k];
                end
            end
            // topmost address pin inverted when used as address
            if (n_cs != 3'h4) begin
                o_pin_out[PORT_ATOP][7] = !acc_addr[23];
            end
            // strobe set chosen by style bit, forced single set when narrow
            o_pin_is_bus[PORT_CTL] = 8'hff;
            o_pin_oe[PORT_CTL] = 8'h1f;
            o_pin_out[PORT_CTL] = 8'hff;
            o_pin_out[PORT_CTL][CTL_READ] = !(strobe && !acc_write);
            o_pin_out[PORT_CTL][CTL_WLO] = split ? !(drive_w && acc_be[0]) : !((state != EBC_IDLE) && acc_be[1]);
            o_pin_out[PORT_CTL][CTL_WHI] = split ? !(drive_w && acc_be[1]) : !drive_w;
            // latch enable placed by the select field
            o_pin_out[PORT_CTL][CTL_CLK] = (latch_sel == LATCH_ON_CLK) ? ale : bclk_now;
            o_pin_out[PORT_CTL][CTL_HACK] = (latch_sel == LATCH_ON_HACK) ? ale : 1'b1;
            if (latch_sel == LATCH_NONE || latch_sel == LATCH_ON_PIN) begin
                o_pin_out[PORT_CTL][CTL_LATCH] = (latch_sel == LATCH_ON_PIN) && ale;
                o_pin_oe[PORT_CTL][CTL_LATCH] = 1'b1;
            end else begin
                o_pin_is_bus[PORT_CTL][CTL_LATCH] = 1'b0;
                o_pin_out[PORT_CTL][CTL_LATCH] = i_io_out[PORT_CTL][CTL_LATCH];
                o_pin_oe[PORT_CTL][CTL_LATCH] = i_io_oe[PORT_CTL][CTL_LATCH];
            end
        end
    end

    // Checks; helper counts bus clock edges spent in the strobe phase
    logic [WAIT_W:0] rise_seen;
    logic [WAIT_W-1:0] wait_seen;
    always_ff @(posedge i_clk) begin
        if (i_srst || state == EBC_IDLE) begin
            rise_seen <= '0;
            wait_seen <= '0;
        end else if (state == EBC_ADDR) begin
            wait_seen <= wait_reg[acc_space];
        end else if (strobe && bclk_rise) begin
            rise_seen <= rise_seen + 1'b1;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    sequence s_take;
        o_acc_ready && i_acc_req;
    endsequence
    sequence s_addr_phase;
        ale && !strobe;
    endsequence

    a_single_chip_io: assert property (!bus_mode |-> o_pin_is_bus == '0)
        else $error("bus pin taken in single-chip mode");
    a_width_write: assert property (i_width_wr |=> width_reg == $past(i_width_data))
        else $error("width write not stored");
    a_strap_width: assert property (strap_cnt == STRAP_DELAY && !i_width_wr
        |=> width_reg[STRAP_SPACE] == !$past(sif.synced[SYNC_STRAP]))
        else $error("strap width wrong");
    a_port_one_io: assert property (bus_mode && !all_mux && !any_wide
        |-> o_pin_is_bus[PORT_DHI] == 8'h00 && o_pin_is_bus[PORT_DLO] == 8'hff)
        else $error("port one not left as I/O");
    a_upper_float: assert property (bus_mode && any_wide && strobe && !cur_mux && !acc_wide |-> o_pin_oe[PORT_DHI] == 8'h00)
        else $error("upper byte driven on narrow access");
    a_wait_length: assert property (state == EBC_DONE |-> rise_seen == ({1'b0, wait_seen} + 1'b1))
        else $error("strobe phase length wrong");
    a_micro_no_mux: assert property (i_proc_mode == MODE_MICRO |-> fmt_eff != FMT_MUX_ALL)
        else $error("all-mux format applied in microprocessor mode");
    a_take_addr: assert property (s_take ##1 s_addr_phase |-> cs_n == ~(4'h1 << acc_space))
        else $error("chip-select not on addressed area");
    a_cs_hold: assert property (state != EBC_IDLE |-> $onehot(~cs_n))
        else $error("more than one chip-select low");
    a_top_inverted: assert property (bus_mode && n_cs != 3'h4 |-> o_pin_out[PORT_ATOP][7] == !acc_addr[23])
        else $error("top address pin not inverted");
    a_read_strobe: assert property (bus_mode && strobe && !acc_write |-> !o_pin_out[PORT_CTL][CTL_READ])
        else $error("read strobe missing");
    a_latch_none: assert property (bus_mode && latch_sel == LATCH_NONE
        |-> o_pin_is_bus[PORT_CTL][CTL_LATCH] && o_pin_oe[PORT_CTL][CTL_LATCH])
        else $error("latch pin freed with no latch selected");
endmodule

/* tb/ebc_mem_model.sv */
/*
  Memory on the far side of the bus pins.
  Assumes it sees the block's pin outputs and enables.
*/
`timescale 1ns/1ps
module ebc_mem_model (
    // Pins from the block
    input wire logic [ebc_pkg::NPORTS-1:0][7:0] i_pin_out,
    input wire logic [ebc_pkg::NPORTS-1:0][7:0] i_pin_oe,
    // Levels back to the block
    output logic [ebc_pkg::NPORTS-1:0][7:0] o_pin_in
);
    import ebc_pkg::*;
    logic rd;
    logic [NPORTS-1:0][7:0] far;
    assign rd = !i_pin_out[PORT_CTL][CTL_READ] && i_pin_oe[PORT_CTL][CTL_READ];
    // Read answers a fixed word; released lines invert so stale data fails
    // Shared lanes answer a different word, so a lane mix-up shows in the data
    assign far = rd ? {~i_pin_out[5:4], 32'h9617a5c3} : ~i_pin_out;
    // Each pin takes whichever party drives it
    assign o_pin_in = (i_pin_oe & i_pin_out) | (~i_pin_oe & far);
endmodule

/* tb/ebc_top_tb_top.sv */
/*
  Self-checking bench for the bus configuration block.
  Assumes the memory model answers reads on the data pins.
*/
`timescale 1ns/1ps
module ebc_top_tb_top;
    import ebc_pkg::*;
    logic i_clk, i_srst, bclk, rwp, stb, wwr, twr, req, wr, rdy, done;
    logic [1:0] mode, fmt, smod, lat, sp, tix;
    logic [3:0] wdat, width;
    logic [4:0] tdat, waits;
    logic [15:0] rdata, wseen;
    logic [NPORTS-1:0][7:0] pin_in, io_out, io_oe, pout, poe, pbus;
    int n_fail, tests_run, cyc;
    ebc_top dut (.i_clk(i_clk), .i_srst(i_srst), .i_proc_mode(mode),
        .i_bus_format_high(fmt[1]), .i_bus_format_low(fmt[0]),
        .i_space_mode_high(smod[1]), .i_space_mode_low(smod[0]),
        .i_latch_pin_sel_high(lat[1]), .i_latch_pin_sel_low(lat[0]),
        .i_strobe_style_bit(stb), .i_width_wr(wwr), .i_width_data(wdat),
        .o_width_select_reg(width), .i_wait_wr(twr), .i_wait_idx(tix),
        .i_wait_data(tdat), .o_wait_states(waits), .i_acc_req(req),
        .i_acc_space(sp), .i_acc_addr(24'h12345a), .i_acc_write(wr),
        .i_acc_byte_en(2'h3), .i_acc_wdata(16'h5a3c), .o_acc_ready(rdy),
        .o_acc_done(done), .o_acc_rdata(rdata), .i_reset_width_pin(rwp),
        .i_bus_clk(bclk), .i_pin_in(pin_in), .i_io_out(io_out), .i_io_oe(io_oe),
        .o_pin_out(pout), .o_pin_oe(poe), .o_pin_is_bus(pbus));
    ebc_mem_model mem (.i_pin_out(pout), .i_pin_oe(poe), .o_pin_in(pin_in));
    // System clock, and a bus clock of unrelated phase
    initial begin
        i_clk = 0;
        forever #20 i_clk = ~i_clk;
    end
    initial begin
        bclk = 0;
        #7;
        forever #160 bclk = ~bclk;
    end
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        if (n_fail == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Hang guard well above the whole sequence
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            wrap_up;
        end
    end
    task automatic cfg(input logic [1:0] m, f, s, l);
        @(posedge i_clk);
        {mode, fmt, smod, lat} <= {m, f, s, l};
        @(posedge i_clk);
        #1;
    endtask
    task automatic ww(input logic [3:0] d);
        @(posedge i_clk);
        wwr <= 1;
        wdat <= d;
        @(posedge i_clk);
        wwr <= 0;
        @(posedge i_clk);
        #1;
    endtask
    // Request is held until the taking edge, done is awaited with a bound
    task automatic acc(input logic [1:0] s, input logic w);
        int k;
        logic [2:0] seen;
        @(posedge i_clk);
        req <= 1;
        sp <= s;
        wr <= w;
        @(posedge i_clk);
        req <= 0;
        k = 0;
        seen = '0;
        wseen = '0;
        do begin
            @(posedge i_clk);
            #1;
            k++;
            // Active-low strobes seen at any point of the access
            seen |= ~pout[5][2:0];
            if (!pout[5][2])
                wseen = {poe[1], pin_in[0]};
        end while (done !== 1 && k < 300);
        chk(k < 300, 1);
        chk(seen[0], !w); // read strobe
        chk(seen[2], w); // write strobe
    endtask
    task automatic t_sep;
        cfg(MODE_EXPAND, FMT_SEP, 2'h3, LATCH_NONE);
        chk(rdy, 1); // bus access offered
        ww(4'h0);
        chk(pbus[1], 0); // narrow idle
        chk(pout[1], io_out[1]); // port one
        chk(pbus[4][3:0], 4'hf); // high address
        chk(pbus[5][6], 1); // no latch
        ww(4'h1);
        chk(width, 4'h1); // width bits
        chk({pbus[1], pbus[0]}, 16'hffff); // wide
        acc(2'h0, 0);
        chk(rdata, 16'ha5c3); // wide read
        chk(pout[4][7:4], 4'he); // select zero
        acc(2'h1, 0);
        chk(rdata, 16'h00c3); // narrow read
        chk(pout[4][7:4], 4'hd); // select one
    endtask
    task automatic t_wait;
        @(posedge i_clk);
        twr <= 1;
        tix <= 2'h2;
        tdat <= 5'h03;
        @(posedge i_clk);
        twr <= 0;
        acc(2'h2, 1);
        chk(wseen, 16'h003c); // upper byte floats on narrow write
        chk(waits, 5'h03); // space wait
        chk(pout[4][7:4], 4'hb); // select two
        cfg(MODE_EXPAND, FMT_SEP, 2'h0, LATCH_ON_CLK);
        chk(pout[4][7:4], 4'h9); // inverted top
        chk(pbus[5][6], 0); // latch moved
    endtask
    task automatic t_mux;
        cfg(MODE_EXPAND, FMT_MUX_CS1, 2'h3, LATCH_ON_HACK);
        chk(pbus[5][6], 0); // latch on hold-ack pin
        acc(2'h0, 0);
        chk(rdata, 16'ha5c3); // area zero separate
        acc(2'h1, 0);
        chk(rdata, 16'h0017); // area one multiplexed
        cfg(MODE_EXPAND, FMT_MUX_ALL, 2'h3, LATCH_ON_PIN);
        chk({pbus[1], pbus[0]}, 16'h0); // data ports free
        chk(pbus[4][3:0], 4'h0); // high address free
        chk(pbus[2], 8'hff); // low lane
        acc(2'h0, 0);
        chk(rdata, 16'h9617); // shared lanes
        chk(pout[3], 8'h34); // address A8-A15 held
        cfg(MODE_MICRO, FMT_MUX_ALL, 2'h3, LATCH_ON_PIN);
        chk(pbus[0], 8'hff); // stays separate
    endtask
    // Main sequence: reset, strap, then each scenario
    initial begin
        i_srst = 1;
        {rwp, stb, wwr, twr, req, wr} = '0;
        n_fail = 0;
        tests_run = 0;
        cyc = 0;
        {mode, fmt, smod, lat, sp, tix, wdat, tdat} = 0;
        io_out = {6{8'h5a}};
        io_oe = {6{8'h0f}};
        repeat (10) @(posedge i_clk);
        i_srst <= 0;
        repeat (5) @(posedge i_clk);
        #1;
        chk(width, 4'h8); // strap width
        chk(pbus, 0); // single chip
        chk(rdy, 0); // no access in single chip
        t_sep;
        t_wait;
        t_mux;
        wrap_up;
    end
endmodule
